// ### pkg/thermal_fault_regs.vh
// thermal fault and interrupt block: offsets-free constants, field positions, strap codes, timing
// assumes inclusion by bare name from rtl files
`ifndef THERMAL_FAULT_REGS_VH
`define THERMAL_FAULT_REGS_VH

// ****************************************
// fault group bit positions
// ****************************************
`define FLT_CONN_HOT        0
`define FLT_BAT_HOT         1
`define FLT_DIE_HOT         2
`define FLT_SHUTDOWN        3
`define FLT_WIDTH           4

// ****************************************
// general interrupt group bit positions
// ****************************************
`define INT_THERM_WARN      0
`define INT_DIE_ALARM       1
`define INT_WIDTH           2

// ****************************************
// strap codes from the resistor sensing comparators
// ****************************************
`define STRAP_18K           2'h0
`define STRAP_39K           2'h1
`define STRAP_75K           2'h2
`define STRAP_OPEN          2'h3

`define ADDR_65             7'h65
`define ADDR_66             7'h66
`define ADDR_67             7'h67

`define ROLE_STANDALONE     2'h0
`define ROLE_LEADER         2'h1
`define ROLE_FOLLOWER       2'h2

`define OVP_DISABLED        2'h0
`define OVP_6V5             2'h1
`define OVP_11V             2'h2

// ****************************************
// thermistor ratio: percent of output rail, 0..50
// ****************************************
`define TS_PCT_MAX          7'h32
`define TS_WARN_MARGIN      7'h05

// ****************************************
// interrupt pulse
// ****************************************
`define CLK_PERIOD_PS       5000
`define INT_PULSE_NS        256
`define INT_PULSE_CYC       ((`INT_PULSE_NS * 1000) / `CLK_PERIOD_PS)
`define STRAP_SETTLE_CYC    16

`endif

// ### rtl/int_pulse_gen.v
// one-shot low pulse generator for the open-drain interrupt pin
// assumes trigger is a single-cycle pulse in the core_clk domain
`timescale 1ns/1ps
module int_pulse_gen #(
  parameter PULSE_CYC = 51
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        trigger,
  output wire        irq_out,
  output wire        irq_oe
);
  reg [15:0] count_q;
  reg [15:0] count_d;

  always @*
  begin
    count_d = count_q;
    if (trigger && (count_q == 16'h0000))
      count_d = PULSE_CYC[15:0];
    else if (count_q != 16'h0000)
      count_d = count_q - 16'h0001;
  end

  always @(posedge core_clk)
  begin
    if (!rstn)
      count_q <= 16'h0000;
    else
      count_q <= count_d;
  end

  // pin drives low only; released otherwise so the pullup holds it high
  assign irq_out = 1'b0;
  assign irq_oe  = (count_q != 16'h0000);
endmodule

// ### rtl/thermal_fault_interrupt_logic.v
// thermistor, die temperature fault/alarm detection with stat/flag/mask interrupt reporting
// strap decoding of address, role and default overvoltage limit; role-dependent pin muxing
// assumes all inputs synchronous to core_clk; analog compares arrive as percent codes or levels
`timescale 1ns/1ps
`include "thermal_fault_regs.vh"
module thermal_fault_interrupt_logic #(
  parameter PCT_W     = 7,
  parameter DIE_W     = 8,
  parameter PULSE_CYC = `INT_PULSE_CYC
) (
  input  wire             core_clk,
  input  wire             rstn,
  input  wire             reg_reset,
  input  wire             input_supply_valid,
  input  wire [PCT_W-1:0] connector_thermistor,
  input  wire [PCT_W-1:0] battery_thermistor,
  input  wire [DIE_W-1:0] die_temperature,
  input  wire [PCT_W-1:0] connector_hot_threshold,
  input  wire [PCT_W-1:0] battery_hot_threshold,
  input  wire [DIE_W-1:0] die_fault_threshold,
  input  wire [DIE_W-1:0] die_alarm_threshold,
  input  wire [DIE_W-1:0] thermal_shutdown_level,
  input  wire             connector_protect_disable,
  input  wire             battery_protect_disable,
  input  wire             die_protect_disable,
  input  wire             die_alarm_disable,
  input  wire             charge_enable_set,
  input  wire [3:0]       fault_mask,
  input  wire [1:0]       int_mask,
  input  wire             fault_flag_read,
  input  wire             int_flag_read,
  input  wire [1:0]       config_strap_pin,
  input  wire             alternate_address_select,
  input  wire             bus_activity,
  input  wire [1:0]       input_overvoltage_reg,
  input  wire             phase_sync_source,
  input  wire             blocker_gate_on,
  input  wire             thermistor_or_sync_out_pin_in,
  input  wire             battery_sense_or_sync_in_pin_in,
  output reg              charge_enable_bit,
  output wire             switching_allowed,
  output reg  [3:0]       fault_status,
  output reg  [3:0]       fault_latched,
  output reg  [1:0]       int_status,
  output reg  [1:0]       int_latched,
  output reg  [6:0]       bus_address,
  output reg  [1:0]       device_role,
  output reg  [1:0]       input_overvoltage_limit,
  output reg              strap_done,
  output wire             int_n_out,
  output wire             int_n_oe,
  output wire             thermistor_or_sync_out_pin_out,
  output wire             thermistor_or_sync_out_pin_oe,
  output wire             phase_sync_input,
  output wire             battery_sense_positive,
  output wire             battery_pin_thermistor,
  output wire             external_blocker_gate_out,
  output wire             external_blocker_gate_oe
);

  // ****************************************
  // helpers
  // ****************************************
  // thresholds clamp to the 0..50 percent span
  function [PCT_W-1:0] clamp_pct;
    input [PCT_W-1:0] v;
    begin
      if (v > `TS_PCT_MAX)
        clamp_pct = `TS_PCT_MAX;
      else
        clamp_pct = v;
    end
  endfunction

  // hot when the pin ratio has fallen to or below the threshold
  function is_hot;
    input [PCT_W-1:0] sense;
    input [PCT_W-1:0] thr;
    begin
      is_hot = (sense <= clamp_pct(thr));
    end
  endfunction

  // warning when at or below the threshold plus the margin
  function is_near;
    input [PCT_W-1:0] sense;
    input [PCT_W-1:0] thr;
    reg   [PCT_W:0]   lim;
    begin
      lim     = {1'b0, clamp_pct(thr)} + {1'b0, `TS_WARN_MARGIN};
      is_near = ({1'b0, sense} <= lim);
    end
  endfunction

  // ****************************************
  // strap capture once after reset
  // ****************************************
  localparam ST_SETTLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_HOLD   = 3'b100;

  reg [2:0] strap_st_q;
  reg [4:0] settle_q;
  reg       bus_seen_q;

  always @(posedge core_clk)
  begin
    if (!rstn || reg_reset)
    begin
      strap_st_q              <= ST_SETTLE;
      settle_q                <= 5'h00;
      strap_done              <= 1'b0;
      bus_address             <= `ADDR_66;
      device_role             <= `ROLE_STANDALONE;
      input_overvoltage_limit <= `OVP_6V5;
      bus_seen_q              <= 1'b0;
    end
    else
    begin
      if (bus_activity && strap_done)
        bus_seen_q <= 1'b1;
      if (bus_seen_q || (bus_activity && strap_done))
        input_overvoltage_limit <= input_overvoltage_reg;
      case (strap_st_q)
        ST_SETTLE:
        begin
          settle_q <= settle_q + 5'h01;
          if (settle_q == (`STRAP_SETTLE_CYC - 1))
            strap_st_q <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          strap_st_q <= ST_HOLD;
          strap_done <= 1'b1;
          case (config_strap_pin)
            `STRAP_18K:
            begin
              bus_address             <= alternate_address_select ? `ADDR_66 : `ADDR_65;
              device_role             <= `ROLE_LEADER;
              input_overvoltage_limit <= `OVP_6V5;
            end
            `STRAP_39K:
            begin
              bus_address             <= alternate_address_select ? `ADDR_67 : `ADDR_66;
              device_role             <= `ROLE_FOLLOWER;
              input_overvoltage_limit <= `OVP_DISABLED;
            end
            `STRAP_75K:
            begin
              bus_address             <= alternate_address_select ? `ADDR_67 : `ADDR_65;
              device_role             <= `ROLE_STANDALONE;
              input_overvoltage_limit <= `OVP_11V;
            end
            default:
            begin
              bus_address             <= alternate_address_select ? `ADDR_67 : `ADDR_66;
              device_role             <= `ROLE_STANDALONE;
              input_overvoltage_limit <= `OVP_6V5;
            end
          endcase
        end
        ST_HOLD:
          strap_st_q <= ST_HOLD;
        default:
          strap_st_q <= ST_SETTLE;
      endcase
    end
  end

  // ****************************************
  // present conditions
  // ****************************************
  wire conn_en = input_supply_valid && !connector_protect_disable;
  wire bat_pin = (device_role == `ROLE_LEADER) ? 1'b0 : 1'b1;
  wire bat_en  = input_supply_valid && !battery_protect_disable && bat_pin;
  wire die_en  = input_supply_valid && !die_protect_disable;

  wire conn_hot  = conn_en && is_hot(connector_thermistor, connector_hot_threshold);
  wire bat_hot   = bat_en && is_hot(battery_thermistor, battery_hot_threshold);
  wire die_hot   = die_en && (die_temperature >= die_fault_threshold);
  wire shutdown  = die_temperature >= thermal_shutdown_level;
  wire therm_warn = (conn_en && is_near(connector_thermistor, connector_hot_threshold)) ||
                    (bat_en && is_near(battery_thermistor, battery_hot_threshold));
  wire die_alarm = input_supply_valid && !die_alarm_disable &&
                   (die_temperature > die_alarm_threshold);

  wire [3:0] fault_now = {shutdown, die_hot, bat_hot, conn_hot};
  wire [1:0] int_now   = {die_alarm, therm_warn};
  // disabled sources hold stat and flag in reset
  wire [3:0] fault_enabled = {1'b1, die_en, bat_en, conn_en};
  wire [1:0] int_enabled   = {input_supply_valid && !die_alarm_disable, conn_en || bat_en};

  // die alarm only informs; switching stops on faults and shutdown
  assign switching_allowed = charge_enable_bit && !conn_hot && !bat_hot && !die_hot && !shutdown;

  // ****************************************
  // charge enable
  // ****************************************
  always @(posedge core_clk)
  begin
    if (!rstn || reg_reset)
      charge_enable_bit <= 1'b0;
    else if (conn_hot || bat_hot)
      charge_enable_bit <= 1'b0;
    else if (charge_enable_set)
      charge_enable_bit <= 1'b1;
  end

  // ****************************************
  // status and flag groups
  // ****************************************
  reg  [3:0] fault_prev_q;
  reg  [1:0] int_prev_q;
  wire [3:0] fault_rise = fault_now & ~fault_prev_q;
  wire [1:0] int_rise   = int_now & ~int_prev_q;

  always @(posedge core_clk)
  begin
    if (!rstn || reg_reset)
    begin
      fault_status  <= 4'h0;
      fault_latched <= 4'h0;
      int_status    <= 2'h0;
      int_latched   <= 2'h0;
      fault_prev_q  <= 4'h0;
      int_prev_q    <= 2'h0;
    end
    else
    begin
      fault_prev_q <= fault_now;
      int_prev_q   <= int_now;
      fault_status <= fault_now & fault_enabled;
      int_status   <= int_now & int_enabled;
      // set wins over read-clear so no event is lost
      fault_latched <= ((fault_flag_read ? 4'h0 : fault_latched) | fault_rise) & fault_enabled;
      int_latched   <= ((int_flag_read ? 2'h0 : int_latched) | int_rise) & int_enabled;
    end
  end

  // ****************************************
  // interrupt pulse
  // ****************************************
  // rising edges only: a persisting event re-arms nothing after a read
  wire [3:0] fault_fire = fault_rise & fault_enabled & ~fault_latched & ~fault_mask;
  wire [1:0] int_fire   = int_rise & int_enabled & ~int_latched & ~int_mask;
  reg        fire_q;

  always @(posedge core_clk)
  begin
    if (!rstn)
      fire_q <= 1'b0;
    else
      fire_q <= (|fault_fire) | (|int_fire);
  end

  int_pulse_gen #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pulse (
    .core_clk (core_clk),
    .rstn     (rstn),
    .trigger  (fire_q),
    .irq_out  (int_n_out),
    .irq_oe   (int_n_oe)
  );

  // ****************************************
  // role-dependent pins
  // ****************************************
  wire leader = (device_role == `ROLE_LEADER);
  assign thermistor_or_sync_out_pin_out = phase_sync_source;
  assign thermistor_or_sync_out_pin_oe  = leader;
  assign battery_sense_positive         = leader ? battery_sense_or_sync_in_pin_in : 1'b0;
  assign phase_sync_input               = (device_role == `ROLE_FOLLOWER) ? battery_sense_or_sync_in_pin_in : 1'b0;
  assign battery_pin_thermistor         = leader ? 1'b0 : thermistor_or_sync_out_pin_in;
  assign external_blocker_gate_out      = blocker_gate_on;
  assign external_blocker_gate_oe       = strap_done && (device_role != `ROLE_FOLLOWER);

endmodule

// ### sim/tfil_sva.sv
// checker for the thermal fault and interrupt block, watching top-level ports only
// assumes a bind from the bench top file and a single core_clk domain
`timescale 1ns/1ps
module tfil_sva #(
  parameter PULSE_CYC = 4
) (
  input wire       core_clk,
  input wire       rstn,
  input wire       reg_reset,
  input wire       input_supply_valid,
  input wire [6:0] connector_thermistor,
  input wire [6:0] connector_hot_threshold,
  input wire       connector_protect_disable,
  input wire [3:0] fault_mask,
  input wire       fault_flag_read,
  input wire [3:0] fault_status,
  input wire [3:0] fault_latched,
  input wire       charge_enable_bit,
  input wire       switching_allowed,
  input wire       int_n_out,
  input wire       int_n_oe,
  input wire [1:0] device_role,
  input wire       external_blocker_gate_oe,
  input wire       strap_done,
  input wire [6:0] bus_address
);
  reg [7:0] len_q;
  always @(posedge core_clk)
  begin
    len_q <= (!rstn || !int_n_oe) ? 8'h00 : len_q + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // interrupt pin
  // ****************************************
  pulse_start_a: assert property ($rose(fault_latched[0]) && !$past(fault_mask[0]) && !int_n_oe &&
    !$past(int_n_oe) |-> ##2 int_n_oe) else $error("no pulse after unmasked flag set");
  pulse_len_a: assert property ($fell(int_n_oe) |-> len_q == PULSE_CYC)
    else $error("interrupt pulse width wrong");
  pin_drive_a: assert property (int_n_oe |-> !int_n_out) else $error("interrupt pin driven high");
  // ****************************************
  // status, flag and protection
  // ****************************************
  status_track_a: assert property (input_supply_valid && !reg_reset && !connector_protect_disable &&
    connector_hot_threshold <= 7'h32 && connector_thermistor <= connector_hot_threshold |=> fault_status[0])
    else $error("connector hot status missing");
  supply_gate_a: assert property (!input_supply_valid |=> fault_status[1:0] == 2'h0)
    else $error("thermistor fault without supply");
  disable_clear_a: assert property (connector_protect_disable |=> !fault_status[0] && !fault_latched[0])
    else $error("disabled bits not held clear");
  charge_drop_a: assert property ($rose(fault_latched[0]) |-> !charge_enable_bit)
    else $error("charge enable kept after fault");
  flag_clear_a: assert property (fault_flag_read ##1 fault_status == $past(fault_status) |->
    fault_latched == 4'h0) else $error("flags not cleared by read");
  shutdown_stop_a: assert property (fault_status[3] |-> !$past(switching_allowed))
    else $error("switching during shutdown");
  follower_gate_a: assert property (device_role == 2'h2 |-> !external_blocker_gate_oe)
    else $error("follower drives gate");
  strap_hold_a: assert property (strap_done && !reg_reset |=> $stable(bus_address) && $stable(device_role))
    else $error("strap result changed");
  pulse_c: cover property ($fell(int_n_oe));
  shutdown_c: cover property (fault_status[3]);
  follower_c: cover property (device_role == 2'h2 && strap_done);
endmodule

// ### sim/host_int_model.sv
// host side model: pulled-up interrupt line, pulse counter, charge start-up
// assumes the open-drain pin is resolved here from the device's enable
`timescale 1ns/1ps
module host_int_model (
  input  wire       core_clk,
  input  wire       int_n_out,
  input  wire       int_n_oe,
  output wire       int_pin,
  output reg  [7:0] pulse_cnt,
  output reg        charge_enable_set
);
  reg pin_q;
  // released line floats to the pull-up level
  assign int_pin = int_n_oe ? int_n_out : 1'h1;
  initial
  begin
    pulse_cnt = 8'h00;
    charge_enable_set = 1'h0;
    pin_q = 1'h1;
  end
  always @(posedge core_clk)
  begin
    pin_q <= int_pin;
    if (pin_q && !int_pin)
      pulse_cnt <= pulse_cnt + 8'h01;
  end
  // start-up has to be repeated before charging resumes
  task restart;
    begin
      @(posedge core_clk) charge_enable_set <= 1'h1;
      @(posedge core_clk) charge_enable_set <= 1'h0;
    end
  endtask
endmodule

// ### sim/thermal_fault_interrupt_logic_tb.sv
// self-checking bench for the thermal fault and interrupt block
// assumes tfil_sva and host_int_model compiled first; pulse shortened to 4 cycles
`timescale 1ns/1ps
module thermal_fault_interrupt_logic_tb;
  reg core_clk = 1'h0, rstn = 1'h0, reg_reset = 1'h0, input_supply_valid = 1'h1;
  reg [6:0] connector_thermistor = 7'h32, battery_thermistor = 7'h32;
  reg [6:0] connector_hot_threshold = 7'h14, battery_hot_threshold = 7'h14;
  reg [7:0] die_temperature = 8'h20, die_fault_threshold = 8'hC0;
  reg [7:0] die_alarm_threshold = 8'h80, thermal_shutdown_level = 8'hE0;
  reg connector_protect_disable = 1'h0, battery_protect_disable = 1'h0;
  reg die_protect_disable = 1'h0, die_alarm_disable = 1'h0;
  reg [3:0] fault_mask = 4'h0;
  reg [1:0] int_mask = 2'h0, config_strap_pin = 2'h3, input_overvoltage_reg = 2'h2;
  reg fault_flag_read = 1'h0, int_flag_read = 1'h0, alternate_address_select = 1'h0, bus_activity = 1'h0;
  reg phase_sync_source = 1'h1, blocker_gate_on = 1'h1;
  reg thermistor_or_sync_out_pin_in = 1'h0, battery_sense_or_sync_in_pin_in = 1'h1;
  wire charge_enable_set, charge_enable_bit, switching_allowed, strap_done, int_n_out, int_n_oe, int_pin;
  wire thermistor_or_sync_out_pin_out, thermistor_or_sync_out_pin_oe, phase_sync_input;
  wire battery_sense_positive, battery_pin_thermistor, external_blocker_gate_out, external_blocker_gate_oe;
  wire [3:0] fault_status, fault_latched;
  wire [1:0] int_status, int_latched, device_role, input_overvoltage_limit;
  wire [6:0] bus_address;
  wire [7:0] pulse_cnt;
  integer error_cnt = 0, total_checks = 0, cyc_cnt = 0;
  thermal_fault_interrupt_logic #(.PULSE_CYC(4)) u_thermal_fault_interrupt_logic (.*);
  host_int_model u_host_int_model (.*);
  always #2.5 core_clk = ~core_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task rd_flags;
    begin
      @(posedge core_clk) {fault_flag_read, int_flag_read} <= 2'h3;
      @(posedge core_clk) {fault_flag_read, int_flag_read} <= 2'h0;
      cyc(8);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge core_clk)
  begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 5000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  task t_conn_fault;
    reg [7:0] p;
    begin
      p = pulse_cnt;
      @(posedge core_clk) connector_thermistor <= 7'h14;
      cyc(2);
      chk(fault_status[0], 8'h01);
      chk(fault_latched[0], 8'h01);
      chk(charge_enable_bit, 8'h00);
      cyc(8);
      chk(pulse_cnt, p + 8'h01);
      rd_flags;
      chk(fault_latched[0], 8'h00);
      chk(fault_status[0], 8'h01);
      chk(pulse_cnt, p + 8'h01);
      @(posedge core_clk) connector_thermistor <= 7'h32;
      u_host_int_model.restart;
      cyc(2);
      chk(charge_enable_bit, 8'h01);
    end
  endtask
  task t_supply_mask;
    reg [7:0] p;
    begin
      p = pulse_cnt;
      @(posedge core_clk) {input_supply_valid, battery_thermistor} <= {1'h0, 7'h0A};
      cyc(3);
      chk(fault_status[1], 8'h00);
      @(posedge core_clk) {input_supply_valid, fault_mask, int_mask} <= {1'h1, 4'h2, 2'h1};
      cyc(10);
      chk({fault_status[1], fault_latched[1]}, 8'h03);
      chk(pulse_cnt, p);
      chk(charge_enable_bit, 8'h00);
      @(posedge core_clk) {battery_thermistor, fault_mask, int_mask} <= {7'h32, 4'h0, 2'h0};
      rd_flags;
    end
  endtask
  task t_warn;
    begin
      @(posedge core_clk) connector_thermistor <= 7'h1A;
      cyc(3);
      chk(int_status[0], 8'h00);
      @(posedge core_clk) connector_thermistor <= 7'h19;
      cyc(3);
      chk({int_status[0], int_latched[0]}, 8'h03);
      @(posedge core_clk) connector_protect_disable <= 1'h1;
      cyc(3);
      chk({int_status[0], fault_status[0]}, 8'h00);
      @(posedge core_clk) {connector_protect_disable, connector_thermistor} <= {1'h0, 7'h32};
      rd_flags;
    end
  endtask
  task t_die;
    reg s;
    begin
      u_host_int_model.restart;
      cyc(2);
      s = switching_allowed;
      chk(s, 8'h01);
      @(posedge core_clk) die_temperature <= 8'h81;
      cyc(3);
      chk(int_status[1], 8'h01);
      chk(switching_allowed, 8'h01);
      @(posedge core_clk) die_temperature <= 8'hE0;
      cyc(3);
      chk(fault_status[3:2], 8'h03);
      chk(switching_allowed, 8'h00);
      @(posedge core_clk) die_protect_disable <= 1'h1;
      cyc(3);
      chk(fault_status[2], 8'h00);
      @(posedge core_clk) {die_protect_disable, die_temperature} <= {1'h0, 8'h20};
      rd_flags;
    end
  endtask
  task t_strap;
    integer i, n;
    reg [1:0] c;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        c = i[1:0];
        @(posedge core_clk) {config_strap_pin, alternate_address_select, reg_reset} <= {c, i[2], 1'h1};
        battery_sense_or_sync_in_pin_in <= i[0];
        @(posedge core_clk) reg_reset <= 1'h0;
        n = 0;
        cyc(2);
        while (strap_done !== 1'h1 && n < 40)
        begin
          cyc(1);
          n = n + 1;
        end
        chk(strap_done, 8'h01);
        @(posedge core_clk) config_strap_pin <= ~c;
        cyc(3);
        chk(bus_address, i[2] ? (c == 2'h0 ? 7'h66 : 7'h67) : (c[0] ? 7'h66 : 7'h65));
        chk(device_role, c == 2'h0 ? 2'h1 : (c == 2'h1 ? 2'h2 : 2'h0));
        chk(input_overvoltage_limit, c == 2'h1 ? 2'h0 : (c == 2'h2 ? 2'h2 : 2'h1));
        if (c == 2'h0)
          chk({thermistor_or_sync_out_pin_oe, battery_sense_positive}, {1'h1, i[0]});
        if (c == 2'h0)
          chk({thermistor_or_sync_out_pin_out, external_blocker_gate_out, external_blocker_gate_oe}, 8'h07);
        if (c == 2'h1)
          chk(battery_pin_thermistor, thermistor_or_sync_out_pin_in);
        if (c == 2'h1)
          chk({external_blocker_gate_oe, phase_sync_input}, {1'h0, i[0]});
      end
      @(posedge core_clk) bus_activity <= 1'h1;
      @(posedge core_clk) bus_activity <= 1'h0;
      cyc(3);
      chk(input_overvoltage_limit, 8'h02);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    u_host_int_model.restart;
    cyc(4);
    t_conn_fault;
    t_supply_mask;
    t_warn;
    t_die;
    t_strap;
    report_and_stop;
  end
endmodule
bind thermal_fault_interrupt_logic tfil_sva #(.PULSE_CYC(PULSE_CYC)) u_tfil_sva (.*);
